// [logic/motor_cmd_pkg.sv]
// Shared constants and carrier types for the serial motor command decoder.
package motor_cmd_pkg;

    // Command byte marker and command codes.
    localparam logic [7:0] CMD_FLAG_MASK   = 8'h80;
    localparam logic [7:0] CMD_TGT_HI_BASE = 8'hc0;
    localparam logic [7:0] CMD_TGT_HI_LAST = 8'hdf;
    localparam logic [7:0] CMD_TGT_REV     = 8'he0;
    localparam logic [7:0] CMD_TGT_FWD     = 8'he1;
    localparam logic [7:0] CMD_FORCE_TGT   = 8'hf2;
    localparam logic [7:0] CMD_FORCE_DUTY  = 8'hf4;
    localparam logic [7:0] CMD_GET_BLOCK   = 8'he5;
    localparam logic [7:0] CMD_RD1_BASE    = 8'h81;
    localparam logic [7:0] CMD_RD1_LAST    = 8'h9a;
    localparam logic [7:0] CMD_RD2_BASE    = 8'ha1;
    localparam logic [7:0] CMD_RD2_LAST    = 8'hba;
    localparam logic [7:0] CMD_RD_HALTING  = 8'hb3;
    localparam logic [7:0] CMD_RD_OCCURRED = 8'hb5;
    localparam logic [7:0] CMD_RD_CHOP     = 8'hec;

    // Variable image: bytes 0 to 25 follow the one-byte read pattern.
    localparam int         VAR_BYTES   = 27;
    localparam logic [7:0] VAR_CHOP_IDX = 8'h1a;

    // Target arithmetic.
    localparam logic [11:0] TGT_MID    = 12'h800;
    localparam logic [16:0] OL_SPAN    = 17'h00258;
    localparam logic [16:0] MAG_MAX    = 17'h0007f;
    localparam logic [3:0]  FB_SHIFT   = 4'h0;

    // Feedback mode codes.
    localparam logic [1:0] FB_NONE   = 2'h0;
    localparam logic [1:0] FB_ANALOG = 2'h1;
    localparam logic [1:0] FB_FREQ   = 2'h2;

    // Side effect applied after a read response.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_HALT = 2'h1;
    localparam logic [1:0] CLR_OCC  = 2'h2;
    localparam logic [1:0] CLR_CHOP = 2'h3;

    // Reset values.
    localparam logic [11:0] TGT_RESET  = 12'h800;
    localparam logic [13:0] DUTY_RESET = 14'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_SEND
    } dec_state_t;

    // Commands handed to the control core.
    typedef struct packed {
        logic [11:0] target;
        logic        target_set;
        logic        stop_motor;
        logic [13:0] duty;
        logic        force_target;
        logic        force_duty;
        logic        clr_halting;
        logic        clr_occurred;
        logic        clr_chop;
    } core_cmd_t;

    // Byte stream towards the host.
    typedef struct packed {
        logic       rx_ready;
        logic       tx_valid;
        logic [7:0] tx_data;
    } byte_link_t;

    typedef struct packed {
        dec_state_t st;
        logic [7:0] cmd;
        logic [1:0] got;
        logic [6:0] d0;
        logic [7:0] idx;
        logic [4:0] left;
        logic [1:0] clr;
        core_cmd_t  core;
        byte_link_t link;
    } dec_regs_t;

endpackage

// [logic/var_byte_sel.sv]
// Byte picker over the variable image, zero past its end.
`timescale 1ns/100ps
module var_byte_sel (
    input  wire logic [motor_cmd_pkg::VAR_BYTES*8-1:0] image,
    input  wire logic [7:0]                            idx,
    output logic      [7:0]                            byte_out
);

    // Reads beyond the image return zero so a long block read is harmless.
    always_comb begin
        byte_out = 8'h00;
        for (int i = 0; i < motor_cmd_pkg::VAR_BYTES; i++) begin
            if (idx == 8'(i)) begin
                byte_out = image[i*8 +: 8];
            end
        end
    end

endmodule

// [logic/serial_motor_command_decoder.sv]
// Compact serial command decoder feeding targets and variable reads.
`timescale 1ns/100ps

// What this block does
// R01: Top bit set starts a new command.
// R02: Command 0xC0 plus low five, seven high.
// R03: Zero low bits give target 32 times data.
// R04: Forward, analog or frequency: 2048 plus 16m.
// R05: Forward open loop: 2048 plus 600m/127.
// R06: Open loop: 127 full speed, 0 stops.
// R07: Reverse 0xE0 subtracts the scaled magnitude.
// R08: Reverse with zero magnitude means stop motor.
// R09: 0xF2 carries signed 14-bit duty cycle.
// R10: Low seven first, sign in bit six.
// R11: 0xF4 uses the same duty encoding.
// R12: 0xE5 block read has no side effects.
// R13: Host keeps block read length 1 to 15.
// R14: Variables go out low byte first.
// R15: 0xA1 plus offset two, 0x81 one.
// R16: 0xB3 returns and clears halting flags.
// R17: 0xB5 returns and clears occurred flags.
// R18: 0xEC returns and clears chopping count.
// R19: Single-byte variables return exactly one byte.
// R20: New command byte discards unfinished command.
// R21: Offset pattern wins over table oddities.
module serial_motor_command_decoder (
    input  wire logic                                  mclk,
    input  wire logic                                  resetn,
    input  wire logic                                  rx_valid,
    input  wire logic [7:0]                            rx_data,
    output logic                                       rx_ready,
    output logic                                       tx_valid,
    output logic      [7:0]                            tx_data,
    input  wire logic                                  tx_ready,
    input  wire logic [1:0]                            fb_mode,
    input  wire logic [motor_cmd_pkg::VAR_BYTES*8-1:0] var_image,
    output logic      [11:0]                           target,
    output logic                                       target_set,
    output logic                                       stop_motor,
    output logic      [13:0]                           duty,
    output logic                                       force_target,
    output logic                                       force_duty,
    output logic                                       clr_halting,
    output logic                                       clr_occurred,
    output logic                                       clr_chop
);

    // Number of data bytes that follow a command byte.
    function automatic logic [1:0] data_len(input logic [7:0] c);
        logic [1:0] n;
        n = 2'h0;
        if (c >= motor_cmd_pkg::CMD_TGT_HI_BASE &&
            c <= motor_cmd_pkg::CMD_TGT_HI_LAST) begin
            n = 2'h1;
        end
        if (c == motor_cmd_pkg::CMD_TGT_REV ||
            c == motor_cmd_pkg::CMD_TGT_FWD) begin
            n = 2'h1;
        end
        if (c == motor_cmd_pkg::CMD_FORCE_TGT ||
            c == motor_cmd_pkg::CMD_FORCE_DUTY ||
            c == motor_cmd_pkg::CMD_GET_BLOCK) begin
            n = 2'h2;
        end
        return n;
    endfunction

    // Scaled low-resolution magnitude; the division truncates, which
    // keeps 127 at exactly full scale and 0 at exactly zero.
    function automatic logic [11:0] lowres_scale(input logic [6:0] m,
                                                 input logic [1:0] mode);
        logic [16:0] p;
        p = 17'(m) * motor_cmd_pkg::OL_SPAN;
        if (mode == motor_cmd_pkg::FB_NONE) begin
            return 12'(p / motor_cmd_pkg::MAG_MAX); // [R05] [R06]
        end
        return {1'b0, m, motor_cmd_pkg::FB_SHIFT}; // [R04]
    endfunction

    motor_cmd_pkg::dec_regs_t s_r;
    motor_cmd_pkg::dec_regs_t s_nxt;
    logic [7:0]               sel_byte;

    var_byte_sel u_sel (
        .image    (var_image),
        .idx      (s_r.idx),
        .byte_out (sel_byte)
    );

    // Next-state logic: byte collection, execution and response streaming.
    always_comb begin
        logic [6:0]  d0;
        logic [6:0]  d1;
        logic [11:0] sc;
        logic        take;
        d0    = s_r.d0;
        d1    = rx_data[6:0];
        sc    = 12'h000;
        take  = rx_valid && s_r.link.rx_ready;
        s_nxt = s_r;
        s_nxt.core.target_set   = 1'b0;
        s_nxt.core.stop_motor   = 1'b0;
        s_nxt.core.force_target = 1'b0;
        s_nxt.core.force_duty   = 1'b0;
        s_nxt.core.clr_halting  = 1'b0;
        s_nxt.core.clr_occurred = 1'b0;
        s_nxt.core.clr_chop     = 1'b0;
        case (s_r.st)
            motor_cmd_pkg::ST_IDLE,
            motor_cmd_pkg::ST_DATA: begin
                if (take && (rx_data & motor_cmd_pkg::CMD_FLAG_MASK) != 8'h00)
                begin
                    // A command byte always restarts decoding. [R01] [R20]
                    s_nxt.cmd = rx_data;
                    s_nxt.got = 2'h0;
                    s_nxt.st  = motor_cmd_pkg::ST_IDLE;
                    s_nxt.clr = motor_cmd_pkg::CLR_NONE;
                    if (data_len(rx_data) != 2'h0) begin
                        s_nxt.st = motor_cmd_pkg::ST_DATA;
                    end else if (rx_data >= motor_cmd_pkg::CMD_RD1_BASE &&
                                 rx_data <= motor_cmd_pkg::CMD_RD1_LAST) begin
                        s_nxt.idx  = rx_data - motor_cmd_pkg::CMD_RD1_BASE;
                        s_nxt.left = 5'h01; // [R15] [R19] [R21]
                        s_nxt.st   = motor_cmd_pkg::ST_SEND;
                    end else if (rx_data >= motor_cmd_pkg::CMD_RD2_BASE &&
                                 rx_data <= motor_cmd_pkg::CMD_RD2_LAST) begin
                        s_nxt.idx  = rx_data - motor_cmd_pkg::CMD_RD2_BASE;
                        s_nxt.left = 5'h02; // [R15] [R21]
                        s_nxt.st   = motor_cmd_pkg::ST_SEND;
                        if (rx_data == motor_cmd_pkg::CMD_RD_HALTING) begin
                            s_nxt.clr = motor_cmd_pkg::CLR_HALT; // [R16]
                        end
                        if (rx_data == motor_cmd_pkg::CMD_RD_OCCURRED) begin
                            s_nxt.clr = motor_cmd_pkg::CLR_OCC; // [R17]
                        end
                    end else if (rx_data == motor_cmd_pkg::CMD_RD_CHOP) begin
                        s_nxt.idx  = motor_cmd_pkg::VAR_CHOP_IDX;
                        s_nxt.left = 5'h01;
                        s_nxt.clr  = motor_cmd_pkg::CLR_CHOP; // [R18]
                        s_nxt.st   = motor_cmd_pkg::ST_SEND;
                    end
                end else if (take && s_r.st == motor_cmd_pkg::ST_DATA) begin
                    // Data bytes carry seven bits only. [R01]
                    if (s_r.got == 2'h0) begin
                        d0 = rx_data[6:0];
                    end
                    s_nxt.d0  = d0;
                    s_nxt.got = s_r.got + 2'h1;
                    if (s_r.got + 2'h1 == data_len(s_r.cmd)) begin
                        s_nxt.st = motor_cmd_pkg::ST_IDLE;
                        sc = lowres_scale(d0, fb_mode);
                        if (s_r.cmd >= motor_cmd_pkg::CMD_TGT_HI_BASE &&
                            s_r.cmd <= motor_cmd_pkg::CMD_TGT_HI_LAST) begin
                            // Low five bits from the command. [R02] [R03]
                            s_nxt.core.target     = {d0, s_r.cmd[4:0]};
                            s_nxt.core.target_set = 1'b1;
                        end
                        if (s_r.cmd == motor_cmd_pkg::CMD_TGT_FWD) begin
                            s_nxt.core.target =
                                motor_cmd_pkg::TGT_MID + sc; // [R04] [R05]
                            s_nxt.core.target_set = 1'b1;
                        end
                        if (s_r.cmd == motor_cmd_pkg::CMD_TGT_REV) begin
                            if (d0 == 7'h00) begin
                                s_nxt.core.stop_motor = 1'b1; // [R08]
                            end else begin
                                s_nxt.core.target =
                                    motor_cmd_pkg::TGT_MID - sc; // [R07]
                                s_nxt.core.target_set = 1'b1;
                            end
                        end
                        if (s_r.cmd == motor_cmd_pkg::CMD_FORCE_TGT) begin
                            s_nxt.core.duty = {d1, d0}; // [R09] [R10]
                            s_nxt.core.force_target = 1'b1;
                        end
                        if (s_r.cmd == motor_cmd_pkg::CMD_FORCE_DUTY) begin
                            s_nxt.core.duty       = {d1, d0}; // [R11]
                            s_nxt.core.force_duty = 1'b1;
                        end
                        if (s_r.cmd == motor_cmd_pkg::CMD_GET_BLOCK) begin
                            // No clear follows a block read. [R12] [R13]
                            s_nxt.idx  = {1'b0, d0};
                            s_nxt.left = {1'b0, d1[3:0]};
                            s_nxt.clr  = motor_cmd_pkg::CLR_NONE;
                            s_nxt.st   = motor_cmd_pkg::ST_SEND;
                        end
                    end
                end
            end
            motor_cmd_pkg::ST_SEND: begin
                // The output slot reloads only once the host took the byte.
                if (!s_r.link.tx_valid || tx_ready) begin
                    if (s_r.left != 5'h00) begin
                        s_nxt.link.tx_data  = sel_byte; // [R14]
                        s_nxt.link.tx_valid = 1'b1;
                        s_nxt.idx  = s_r.idx + 8'h01;
                        s_nxt.left = s_r.left - 5'h01;
                    end else begin
                        // Clear only after the last byte left the block.
                        s_nxt.link.tx_valid = 1'b0;
                        s_nxt.st = motor_cmd_pkg::ST_IDLE;
                        s_nxt.core.clr_halting =
                            s_r.clr == motor_cmd_pkg::CLR_HALT; // [R16]
                        s_nxt.core.clr_occurred =
                            s_r.clr == motor_cmd_pkg::CLR_OCC; // [R17]
                        s_nxt.core.clr_chop =
                            s_r.clr == motor_cmd_pkg::CLR_CHOP; // [R18]
                    end
                end
            end
            default: begin
                s_nxt.st = motor_cmd_pkg::ST_IDLE;
            end
        endcase
        // Input is held off while a response is streaming out.
        s_nxt.link.rx_ready = s_nxt.st != motor_cmd_pkg::ST_SEND;
    end

    // State register.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r           <= '0;
            s_r.st        <= motor_cmd_pkg::ST_IDLE;
            s_r.core.target <= motor_cmd_pkg::TGT_RESET;
            s_r.core.duty <= motor_cmd_pkg::DUTY_RESET;
            s_r.link.rx_ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output is a field of the state register.
    assign rx_ready     = s_r.link.rx_ready;
    assign tx_valid     = s_r.link.tx_valid;
    assign tx_data      = s_r.link.tx_data;
    assign target       = s_r.core.target;
    assign target_set   = s_r.core.target_set;
    assign stop_motor   = s_r.core.stop_motor;
    assign duty         = s_r.core.duty;
    assign force_target = s_r.core.force_target;
    assign force_duty   = s_r.core.force_duty;
    assign clr_halting  = s_r.core.clr_halting;
    assign clr_occurred = s_r.core.clr_occurred;
    assign clr_chop     = s_r.core.clr_chop;

endmodule

// [testbench/motor_cmd_chk.sv]
// Port-level assertions for the serial motor command decoder.
`timescale 1ns/100ps
module motor_cmd_chk (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready,
    input wire logic [1:0]  fb_mode,
    input wire logic [11:0] target,
    input wire logic        target_set,
    input wire logic        stop_motor,
    input wire logic [13:0] duty,
    input wire logic        force_target,
    input wire logic        force_duty,
    input wire logic        clr_halting,
    input wire logic        clr_occurred,
    input wire logic        clr_chop
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Last two accepted bytes, so each data byte can be tied to its command.
    logic [7:0] b1_r;
    logic [7:0] b2_r;
    wire        acc = rx_valid && rx_ready;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            b1_r <= 8'h00;
            b2_r <= 8'h00;
        end else if (acc) begin
            b1_r <= rx_data;
            b2_r <= b1_r;
        end
    end

    hi_target_a: assert property (
        acc && !rx_data[7] && b1_r[7:5] == 3'h6 |=> target_set
        && target == {$past(rx_data[6:0]), $past(b1_r[4:0])})
        else $error("high resolution target wrong");
    fwd_fb_a: assert property (
        acc && !rx_data[7] && b1_r == 8'he1 && fb_mode != 2'h0 |=>
        target_set && target == 12'h800 + {$past(rx_data[6:0]), 4'h0})
        else $error("forward target with feedback wrong");
    ol_fwd_a: assert property (
        acc && !rx_data[7] && b1_r == 8'he1 && fb_mode == 2'h0 |=>
        target_set &&
        target == 12'(17'h800 + 17'($past(rx_data[6:0])) * 17'h258 / 17'h7f))
        else $error("open loop forward target wrong");
    rev_stop_a: assert property (
        acc && rx_data == 8'h00 && b1_r == 8'he0 |=> stop_motor && !target_set)
        else $error("zero reverse did not stop");
    duty_cmd_a: assert property (
        acc && !rx_data[7] && !b1_r[7] && (b2_r == 8'hf2 || b2_r == 8'hf4)
        |=> duty == {$past(rx_data[6:0]), $past(b1_r[6:0])}
        && force_target == ($past(b2_r) == 8'hf2)
        && force_duty == ($past(b2_r) == 8'hf4))
        else $error("forced duty wrong");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte dropped while stalled");
    pulse_cause_a: assert property (
        target_set || stop_motor || force_target || force_duty |-> $past(acc))
        else $error("command pulse without a received byte");
    halt_read_a: assert property (
        acc && rx_data == 8'hb3 |-> ##[1:3] tx_valid ##[1:40] clr_halting)
        else $error("halting flags read did not clear");
    occ_read_a: assert property (
        acc && rx_data == 8'hb5 |-> ##[1:3] tx_valid ##[1:40] clr_occurred)
        else $error("occurred flags read did not clear");
    chop_read_a: assert property (
        acc && rx_data == 8'hec |-> ##[1:3] tx_valid ##[1:40] clr_chop)
        else $error("chopping count read did not clear");
    block_clean_a: assert property (
        acc && !rx_data[7] && !b1_r[7] && b2_r == 8'he5
        |=> (!clr_halting && !clr_chop) [*8])
        else $error("block read cleared a variable");

    hi_target_c: cover property (acc && b1_r == 8'hdd && rx_data == 8'h64);
    rev_stop_c: cover property (stop_motor);
    stall_c: cover property (tx_valid && !tx_ready);
endmodule

bind serial_motor_command_decoder motor_cmd_chk chk_u (
    .mclk(mclk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .fb_mode(fb_mode), .target(target),
    .target_set(target_set), .stop_motor(stop_motor), .duty(duty),
    .force_target(force_target), .force_duty(force_duty),
    .clr_halting(clr_halting), .clr_occurred(clr_occurred),
    .clr_chop(clr_chop));

// [testbench/host_side_model.sv]
// Host side that takes response bytes, promptly or with stalls.
`timescale 1ns/100ps
module host_side_model (
    input  wire logic mclk,
    input  wire logic slow,
    output logic      tx_ready
);
    logic [1:0] ph_r = 2'h0;
    initial tx_ready = 1'b0;
    // A slow host is ready one cycle in four, to exercise held bytes.
    always @(negedge mclk) begin
        ph_r <= ph_r + 2'h1;
        tx_ready <= !slow || ph_r == 2'h3;
    end
endmodule

// [testbench/test_serial_motor_command_decoder.sv]
// Self-checking bench for the serial motor command decoder.
`timescale 1ns/100ps
module test_serial_motor_command_decoder;
    logic        mclk = 1'b0, resetn = 1'b0, slow = 1'b0, tx_ready;
    logic        rx_valid = 1'b0, rx_ready, tx_valid, target_set, stop_motor;
    logic        force_target, force_duty, clr_halting, clr_occurred, clr_chop;
    logic [7:0]  rx_data = 8'h00, tx_data, img[27];
    logic [1:0]  fb_mode = 2'h0;
    logic [11:0] target;
    logic [13:0] duty;
    logic [215:0] var_image;
    logic [31:0] seed = 32'h70a, evq[$], eev[$];
    logic [7:0]  txq[$], etx[$];
    int          failures = 0, n_checks = 0;

    serial_motor_command_decoder dut_u (.mclk(mclk), .resetn(resetn),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .fb_mode(fb_mode), .var_image(var_image), .target(target),
        .target_set(target_set), .stop_motor(stop_motor), .duty(duty),
        .force_target(force_target), .force_duty(force_duty),
        .clr_halting(clr_halting), .clr_occurred(clr_occurred),
        .clr_chop(clr_chop));
    host_side_model host_u (.mclk(mclk), .slow(slow), .tx_ready(tx_ready));

    initial forever #25 mclk = ~mclk;
    always_comb foreach (img[i]) var_image[8*i +: 8] = img[i];

    function automatic int rnd(int n);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % n);
    endfunction
    // Kind in the top half keeps unknown payload bits visible to compares.
    function automatic logic [31:0] ev(int k, logic [13:0] v);
        return {k[15:0], 2'h0, v};
    endfunction

    // Record every pulse and every byte the host takes, as they happen.
    always @(posedge mclk) begin
        if (tx_valid === 1'b1 && tx_ready) txq.push_back(tx_data);
        if (target_set) evq.push_back(ev(1, {2'h0, target}));
        if (stop_motor) evq.push_back(ev(2, 14'h0));
        if (force_target) evq.push_back(ev(3, duty));
        if (force_duty) evq.push_back(ev(4, duty));
        if (clr_halting) evq.push_back(ev(5, 14'h0));
        if (clr_occurred) evq.push_back(ev(6, 14'h0));
        if (clr_chop) evq.push_back(ev(7, 14'h0));
    end

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Pulses handed to the control core, kind and payload together.
    task automatic chk_ev(logic [31:0] got, logic [31:0] exp);
        chk(got, exp, "event");
    endtask

    // Response bytes in the order the host took them.
    task automatic chk_tx(logic [7:0] got, logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp}, "byte");
    endtask

    // Offer one byte and hold it until the decoder takes it.
    task automatic put(logic [7:0] b);
        int k;
        k = 0;
        @(negedge mclk);
        rx_valid = 1'b1;
        rx_data = b;
        do begin
            @(posedge mclk);
            k++;
        end while (rx_ready !== 1'b1 && k < 200);
    endtask

    // Send a command, wait for the decoder to go quiet, compare all results.
    task automatic run(int n, logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
        int k;
        k = 0;
        put(b0);
        if (n > 1) put(b1);
        if (n > 2) put(b2);
        @(negedge mclk);
        rx_valid = 1'b0;
        repeat (3) @(negedge mclk);
        while ((rx_ready !== 1'b1 || tx_valid !== 1'b0) && k < 400) begin
            @(negedge mclk);
            k++;
        end
        repeat (3) @(negedge mclk);
        chk(evq.size(), eev.size(), "event count");
        foreach (eev[i]) if (i < evq.size()) chk_ev(evq[i], eev[i]);
        chk(txq.size(), etx.size(), "byte count");
        foreach (etx[i]) if (i < txq.size()) chk_tx(txq[i], etx[i]);
        evq = {};
        eev = {};
        txq = {};
        etx = {};
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // The whole run needs under two thousand cycles; 20000 means a hang.
    initial begin
        #(50 * 20000);
        failures++;
        summarize();
    end

    initial begin
        int t, m, d, o, l;
        foreach (img[i]) img[i] = 8'(rnd(256));
        repeat (3) @(negedge mclk);
        chk(target, 12'h800, "reset target");
        chk(duty, 14'h0, "reset duty");
        chk({rx_ready, tx_valid}, 2'h2, "reset link");
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        eev.push_back(ev(1, 3229));
        run(2, 8'hdd, 8'h64);
        for (int i = 0; i < 8; i++) begin
            t = (i < 3) ? 32 * rnd(128) : rnd(4096);
            eev.push_back(ev(1, t));
            run(2, 8'hc0 + 8'(t % 32), 8'(t / 32));
        end
        // A stray data byte and a cut-off command must leave no trace.
        fb_mode = 2'h1;
        eev.push_back(ev(1, 2048 + 80));
        put(8'h15);
        put(8'hc3);
        run(2, 8'he1, 8'h05);
        for (int f = 0; f < 3; f++) begin
            fb_mode = 2'(f);
            for (int i = 0; i < 3; i++) begin
                m = (i == 0) ? 0 : (i == 1) ? 127 : 1 + rnd(126);
                t = (f == 0) ? 600 * m / 127 : 16 * m;
                eev.push_back(ev(1, 2048 + t));
                run(2, 8'he1, 8'(m));
                eev.push_back(m == 0 ? ev(2, 0) : ev(1, 2048 - t));
                run(2, 8'he0, 8'(m));
            end
        end
        for (int i = 0; i < 8; i++) begin
            d = (i % 4 == 0) ? -300 : (i % 4 == 1) ? -600 : 600;
            if (i % 4 == 3) d = rnd(1201) - 600;
            eev.push_back(ev((i < 4) ? 3 : 4, d));
            run(3, (i < 4) ? 8'hf2 : 8'hf4, 8'(d & 127),
                8'((d >> 7) & 127));
        end
        for (int k = 0; k < 26; k++) begin
            slow = rnd(2) == 1;
            etx.push_back(img[k]);
            run(1, 8'h81 + 8'(k));
            etx.push_back(img[k]);
            etx.push_back(img[k + 1]);
            if (k == 18 || k == 20) eev.push_back(ev(k == 18 ? 5 : 6, 0));
            run(1, 8'ha1 + 8'(k));
        end
        etx.push_back(img[26]);
        eev.push_back(ev(7, 0));
        run(1, 8'hec);
        for (int i = 0; i < 6; i++) begin
            o = rnd(32);
            l = 1 + rnd(15);
            for (int j = 0; j < l; j++)
                etx.push_back(o + j < 27 ? img[o + j] : 8'h00);
            run(3, 8'he5, 8'(o), 8'(l));
        end
        // A command sent during a stalled response waits its turn.
        slow = 1'b1;
        etx.push_back(img[20]);
        etx.push_back(img[21]);
        eev.push_back(ev(6, 0));
        eev.push_back(ev(1, 32 * 17 + 5));
        put(8'hb5);
        run(2, 8'hc5, 8'h11);
        summarize();
    end
endmodule
